// [rtl/urd_pkg.sv]
// Purpose: Shared constants and types for the receive DMA completion block
// Assumes: One clock, SYS_CLK at 100 MHz
// Notes:   Endpoint count and widths are fixed
package urd_pkg;
  // ==========================================================
  // Sizes
  localparam int          URD_NUM_EP     = 4;
  localparam int          URD_EP_W       = 2;
  localparam int          URD_LEN_W      = 16;
  localparam int          URD_DATA_W     = 8;
  localparam int          URD_MAX_PKT    = 64;
  // ==========================================================
  // Reset values
  localparam logic [15:0] URD_LEN_RST    = 16'h0000;
  localparam logic [3:0]  URD_EP_RST     = 4'h0;
  // ==========================================================
  // Teardown wait
  localparam int          URD_CLK_MHZ    = 100;
  localparam int          URD_TD_WAIT_MS = 250;
  localparam int          URD_TD_WAIT_CYC = URD_TD_WAIT_MS * 1000
                                            * URD_CLK_MHZ;
  // ==========================================================
  // Engine states
  typedef enum logic [1:0] {
    URD_IDLE,
    URD_DATA,
    URD_DESC
  } urd_state_t;
  // Host states
  typedef enum logic [2:0] {
    URH_IDLE,
    URH_ARM,
    URH_RUN,
    URH_TD_DIS,
    URH_TD_WAIT,
    URH_TD_GO
  } urh_state_t;
endpackage

// [rtl/urd_if.sv]
// Purpose: Link between the receive DMA engine and its software side
// Assumes: All signals synchronous to SYS_CLK
// Notes:   Per-endpoint vectors, bit index is the endpoint
`timescale 1ns/1ps
interface urd_if;
  import urd_pkg::*;
  logic [URD_NUM_EP-1:0] dma_en;
  logic [URD_NUM_EP-1:0] arm;
  logic [URD_LEN_W-1:0]  xfer_size;
  logic [URD_EP_W-1:0]   arm_ep;
  logic                  teardown;
  logic [URD_EP_W-1:0]   td_ep;
  logic                  phy_reset;
  logic [URD_NUM_EP-1:0] active;
  logic                  done;
  logic [URD_EP_W-1:0]   done_ep;
  logic [URD_LEN_W-1:0]  done_len;
  logic                  hung;
  logic                  link_ok;
  modport dev  (input  dma_en, arm, xfer_size, arm_ep, teardown, td_ep,
                       phy_reset,
                output active, done, done_ep, done_len, hung, link_ok);
  modport host (output dma_en, arm, xfer_size, arm_ep, teardown, td_ep,
                       phy_reset,
                input  active, done, done_ep, done_len, hung, link_ok);
endinterface

// [rtl/urd_dev.sv]
// Purpose: Receive DMA engine end, completion and teardown behaviour
// Assumes: Packets arrive per endpoint on a byte stream
// Notes:   Models the affected revision, faults included
// Function
// - Short packet closes the serviced endpoint transfer
// - Short status reaches every active endpoint
// - Descriptor completes early from propagated status
// - Software records programmed size per endpoint
// - Software compares sizes, rearms remainder on mismatch
// - Teardown while active, repeatedly, hangs engine
// - Software clears enable before teardown
// - Software waits 250 ms during teardown
// - PLL loss breaks traffic until PHY reset
// - Data written before descriptor length, actual count
`timescale 1ns/1ps
module urd_dev
  import urd_pkg::*;
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RSTN,
  urd_if.dev                         LNK,
  input  wire logic                  RX_VALID,
  input  wire logic [URD_EP_W-1:0]   RX_EP,
  input  wire logic [URD_DATA_W-1:0] RX_DATA,
  input  wire logic                  RX_LAST,
  input  wire logic                  PLL_LOCK,
  output logic                       BUF_WE,
  output logic [URD_LEN_W-1:0]       BUF_ADDR,
  output logic [URD_DATA_W-1:0]      BUF_DATA,
  output logic                       DESC_WE,
  output logic [URD_EP_W-1:0]        DESC_EP,
  output logic [URD_LEN_W-1:0]       DESC_LEN
);
  // ==========================================================
  // Per-endpoint state
  logic [URD_NUM_EP-1:0] active;
  logic [URD_NUM_EP-1:0] close_pend;
  logic [URD_LEN_W-1:0]  size  [URD_NUM_EP];
  logic [URD_LEN_W-1:0]  count [URD_NUM_EP];
  logic [6:0]            pkt_len;
  logic                  hung;
  logic                  broken;
  logic                  td_strike;
  urd_state_t            state;
  logic [URD_EP_W-1:0]   cl_ep;
  logic                  done;
  logic [URD_EP_W-1:0]   done_ep;
  logic [URD_LEN_W-1:0]  done_len;

  // ==========================================================
  // Decode
  wire                  take     = RX_VALID && !hung && !broken
                                   && active[RX_EP];
  wire [URD_LEN_W-1:0]  next_cnt = count[RX_EP] + 16'h0001;
  wire                  pkt_end  = take && RX_LAST;
  wire                  short    = pkt_end
                                   && (pkt_len < 7'(URD_MAX_PKT - 1));
  wire                  full     = take && (next_cnt == size[RX_EP]);
  // Teardown on a live endpoint is the hazard; a second one hangs
  wire                  td_live  = LNK.teardown && active[LNK.td_ep]
                                   && LNK.dma_en[LNK.td_ep];
  wire [URD_NUM_EP-1:0] pend_any = close_pend;
  wire [URD_EP_W-1:0]   pick;
  assign pick = pend_any[0] ? 2'h0 : pend_any[1] ? 2'h1 :
                pend_any[2] ? 2'h2 : 2'h3;

  // ==========================================================
  // Link and fault state
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      broken    <= 1'b0;
      hung      <= 1'b0;
      td_strike <= 1'b0;
    end else begin
      if (LNK.phy_reset) begin
        broken <= 1'b0;
      end else if (!PLL_LOCK) begin
        broken <= 1'b1;
      end
      if (td_live) begin
        td_strike <= 1'b1;
        if (td_strike) begin
          hung <= 1'b1;
        end
      end else if (LNK.teardown) begin
        td_strike <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Endpoint arming, counting and closing
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      active     <= URD_EP_RST;
      close_pend <= URD_EP_RST;
      pkt_len    <= 7'h00;
      for (int i = 0; i < URD_NUM_EP; i++) begin
        size[i]  <= URD_LEN_RST;
        count[i] <= URD_LEN_RST;
      end
    end else begin
      if (LNK.arm[LNK.arm_ep] && LNK.dma_en[LNK.arm_ep] && !hung
          && !active[LNK.arm_ep]) begin
        active[LNK.arm_ep] <= 1'b1;
        size[LNK.arm_ep]   <= LNK.xfer_size;
        count[LNK.arm_ep]  <= URD_LEN_RST;
      end
      if (take) begin
        count[RX_EP] <= next_cnt;
        pkt_len      <= RX_LAST ? 7'h00 : pkt_len + 7'h01;
      end
      if (short) begin
        close_pend <= close_pend | active;
      end else if (full) begin
        close_pend[RX_EP] <= 1'b1;
      end
      if (LNK.teardown && !hung) begin
        active[LNK.td_ep] <= 1'b0;
      end
      if (state == URD_DESC) begin
        active[cl_ep]     <= 1'b0;
        close_pend[cl_ep] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Completion writer: data first, descriptor length last
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= URD_IDLE;
      cl_ep    <= 2'h0;
      BUF_WE   <= 1'b0;
      BUF_ADDR <= URD_LEN_RST;
      BUF_DATA <= 8'h00;
      DESC_WE  <= 1'b0;
      DESC_EP  <= 2'h0;
      DESC_LEN <= URD_LEN_RST;
      done     <= 1'b0;
      done_ep  <= 2'h0;
      done_len <= URD_LEN_RST;
    end else begin
      BUF_WE   <= take;
      BUF_ADDR <= count[RX_EP];
      BUF_DATA <= RX_DATA;
      DESC_WE  <= 1'b0;
      done     <= 1'b0;
      unique case (state)
        URD_IDLE: begin
          if (|close_pend && !take) begin
            cl_ep <= pick;
            state <= URD_DATA;
          end
        end
        URD_DATA: begin
          // One spare cycle lets the last buffer write land first
          state <= URD_DESC;
        end
        URD_DESC: begin
          DESC_WE  <= 1'b1;
          DESC_EP  <= cl_ep;
          DESC_LEN <= count[cl_ep];
          done     <= 1'b1;
          done_ep  <= cl_ep;
          done_len <= count[cl_ep];
          state    <= URD_IDLE;
        end
      endcase
    end
  end

  assign LNK.active   = active;
  assign LNK.done     = done;
  assign LNK.done_ep  = done_ep;
  assign LNK.done_len = done_len;
  assign LNK.hung     = hung;
  assign LNK.link_ok  = !broken;
endmodule

// [rtl/urd_host.sv]
// Purpose: Software side that arms, checks and tears down receive transfers
// Assumes: Wait length is a parameter so simulation can shorten it
// Notes:   Rearms remainder when a descriptor completes short
`timescale 1ns/1ps
module urd_host
  import urd_pkg::*;
#(
  parameter int TD_WAIT_CYC = URD_TD_WAIT_CYC
)(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RSTN,
  urd_if.host                       LNK,
  input  wire logic                 REQ_ARM,
  input  wire logic [URD_EP_W-1:0]  REQ_EP,
  input  wire logic [URD_LEN_W-1:0] REQ_SIZE,
  input  wire logic                 REQ_TD,
  input  wire logic                 REQ_PHY_RST,
  output logic                      BUSY,
  output logic                      XFER_DONE,
  output logic [URD_EP_W-1:0]       XFER_EP
);
  // ==========================================================
  // Recorded sizes and control
  logic [URD_LEN_W-1:0]  want [URD_NUM_EP];
  logic [URD_NUM_EP-1:0] dma_en;
  logic [URD_NUM_EP-1:0] arm;
  logic [URD_LEN_W-1:0]  xfer_size;
  logic [URD_EP_W-1:0]   ep;
  logic                  teardown;
  logic                  phy_reset;
  logic [31:0]           wait_cnt;
  urh_state_t            state;

  wire [URD_LEN_W-1:0] rest  = want[LNK.done_ep] - LNK.done_len;
  wire                 short = LNK.done && (rest != URD_LEN_RST);

  // ==========================================================
  // Sequencer
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state     <= URH_IDLE;
      dma_en    <= URD_EP_RST;
      arm       <= URD_EP_RST;
      xfer_size <= URD_LEN_RST;
      ep        <= 2'h0;
      teardown  <= 1'b0;
      phy_reset <= 1'b0;
      wait_cnt  <= 32'h0;
      BUSY      <= 1'b0;
      XFER_DONE <= 1'b0;
      XFER_EP   <= 2'h0;
      for (int i = 0; i < URD_NUM_EP; i++) begin
        want[i] <= URD_LEN_RST;
      end
    end else begin
      arm       <= URD_EP_RST;
      teardown  <= 1'b0;
      phy_reset <= REQ_PHY_RST;
      XFER_DONE <= LNK.done && !short;
      XFER_EP   <= LNK.done_ep;
      if (short) begin
        // Remainder rearmed at once, in any host state; idle defers REQ_ARM
        want[LNK.done_ep]     <= rest;
        arm[LNK.done_ep]      <= 1'b1;
        xfer_size             <= rest;
        ep                    <= LNK.done_ep;
      end
      unique case (state)
        URH_IDLE: begin
          BUSY <= 1'b0;
          if (REQ_TD) begin
            ep    <= REQ_EP;
            BUSY  <= 1'b1;
            state <= URH_TD_DIS;
          end else if (REQ_ARM && !short) begin
            want[REQ_EP]   <= REQ_SIZE;
            dma_en[REQ_EP] <= 1'b1;
            xfer_size      <= REQ_SIZE;
            ep             <= REQ_EP;
            BUSY           <= 1'b1;
            state          <= URH_ARM;
          end
        end
        URH_ARM: begin
          arm[ep] <= 1'b1;
          state   <= URH_RUN;
        end
        URH_RUN: begin
          BUSY  <= 1'b0;
          state <= URH_IDLE;
        end
        URH_TD_DIS: begin
          dma_en[ep] <= 1'b0;
          wait_cnt   <= 32'(TD_WAIT_CYC);
          state      <= URH_TD_WAIT;
        end
        URH_TD_WAIT: begin
          if (wait_cnt <= 32'h1) begin
            state <= URH_TD_GO;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        URH_TD_GO: begin
          teardown <= 1'b1;
          BUSY     <= 1'b0;
          state    <= URH_IDLE;
        end
      endcase
    end
  end

  assign LNK.dma_en    = dma_en;
  assign LNK.arm       = arm;
  assign LNK.xfer_size = xfer_size;
  assign LNK.arm_ep    = ep;
  assign LNK.teardown  = teardown;
  assign LNK.td_ep     = ep;
  assign LNK.phy_reset = phy_reset;
endmodule

// [testbench/urd_properties.sv]
// Purpose: Interface checks between the two receive DMA ends
// Assumes: One clock, RSTN asynchronous active low
// Notes:   TD_WAIT_CYC must match the host instance
`timescale 1ns/1ps
module urd_properties
  import urd_pkg::*;
#(
  parameter int TD_WAIT_CYC = 10
)(
  input wire logic                  SYS_CLK,
  input wire logic                  RSTN,
  input wire logic [URD_NUM_EP-1:0] dma_en,
  input wire logic [URD_NUM_EP-1:0] arm,
  input wire logic [URD_NUM_EP-1:0] active,
  input wire logic                  teardown,
  input wire logic [URD_EP_W-1:0]   td_ep,
  input wire logic                  phy_reset,
  input wire logic                  done,
  input wire logic                  hung,
  input wire logic                  link_ok
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // ====
  // Cycles the torn-down channel has been disabled
  int off_cnt;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) off_cnt <= 0;
    else if (dma_en[td_ep]) off_cnt <= 0;
    else off_cnt <= off_cnt + 1;
  end
  property p_arm_onehot; |arm |-> $onehot(arm); endproperty
  a_arm_onehot: assert property (p_arm_onehot)
    else $error("arm on several channels");
  property p_arm_en; |arm |-> ~|(arm & ~dma_en); endproperty
  a_arm_en: assert property (p_arm_en)
    else $error("arm without enable");
  property p_act_en;
    |(active & ~$past(active)) |-> ~|(active & ~$past(active) & ~dma_en);
  endproperty
  a_act_en: assert property (p_act_en)
    else $error("channel started while disabled");
  property p_td_dis; teardown |-> !dma_en[td_ep]; endproperty
  a_td_dis: assert property (p_td_dis)
    else $error("teardown with enable set");
  property p_td_wait; teardown |-> off_cnt >= TD_WAIT_CYC - 1; endproperty
  a_td_wait: assert property (p_td_wait)
    else $error("teardown before wait ran out");
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_hung_hold; hung |=> hung; endproperty
  a_hung_hold: assert property (p_hung_hold)
    else $error("hang cleared without reset");
  property p_link_hold;
    $rose(link_ok) |-> phy_reset || $past(phy_reset) || $past(phy_reset, 2);
  endproperty
  a_link_hold: assert property (p_link_hold)
    else $error("link back without phy reset");
endmodule

// [testbench/testbench.sv]
// Purpose: Both ends joined, one task per scenario
// Assumes: Teardown wait shortened to 10 cycles
// Notes:   Expectations come from the packet sizes sent
`timescale 1ns/1ps
module testbench;
  import urd_pkg::*;
  logic                  sys_clk, rstn, rx_valid, rx_last, pll_lock;
  logic                  req_arm, req_td, req_phy_rst;
  logic                  buf_we, desc_we, busy, xfer_done;
  logic [URD_EP_W-1:0]   rx_ep, req_ep, desc_ep, xfer_ep;
  logic [URD_DATA_W-1:0] rx_data, buf_data;
  logic [URD_LEN_W-1:0]  req_size, buf_addr, desc_len, sz1;
  logic [17:0]           dq[$];
  int                    n_fail = 0, n_checks = 0, n_buf = 0, nb_d = 0;
  int                    n_desc = 0, n_xd = 0, n_a1 = 0, n_td = 0;
  logic [URD_LEN_W-1:0]  lb_addr = '0;
  logic [URD_DATA_W-1:0] lb_data = '0;
  urd_if lnk();
  urd_dev u_urd_dev(.SYS_CLK(sys_clk), .RSTN(rstn), .LNK(lnk),
    .RX_VALID(rx_valid), .RX_EP(rx_ep), .RX_DATA(rx_data),
    .RX_LAST(rx_last), .PLL_LOCK(pll_lock), .BUF_WE(buf_we),
    .BUF_ADDR(buf_addr), .BUF_DATA(buf_data), .DESC_WE(desc_we),
    .DESC_EP(desc_ep), .DESC_LEN(desc_len));
  urd_host #(.TD_WAIT_CYC(10)) u_urd_host(.SYS_CLK(sys_clk),
    .RSTN(rstn), .LNK(lnk), .REQ_ARM(req_arm), .REQ_EP(req_ep),
    .REQ_SIZE(req_size), .REQ_TD(req_td), .REQ_PHY_RST(req_phy_rst),
    .BUSY(busy), .XFER_DONE(xfer_done), .XFER_EP(xfer_ep));
  urd_properties #(.TD_WAIT_CYC(10)) u_urd_properties(
    .SYS_CLK(sys_clk), .RSTN(rstn), .dma_en(lnk.dma_en),
    .arm(lnk.arm), .active(lnk.active), .teardown(lnk.teardown),
    .td_ep(lnk.td_ep), .phy_reset(lnk.phy_reset), .done(lnk.done),
    .hung(lnk.hung), .link_ok(lnk.link_ok));
  // ====
  // Event counters, so waits stay bounded loops on plain ints
  always @(posedge sys_clk) begin
    if (buf_we) begin
      n_buf++;
      lb_addr = buf_addr;
      lb_data = buf_data;
    end
    if (desc_we) begin
      dq.push_back({desc_ep, desc_len});
      nb_d = n_buf;
      n_desc++;
    end
    if (xfer_done) n_xd++;
    if (lnk.arm[1]) begin
      sz1 = lnk.xfer_size;
      n_a1++;
    end
    if (lnk.teardown) n_td++;
  end
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ====
  // Shared tasks
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_ge(ref int c, input int n);
    for (int i = 0; i < 200 && c < n; i++) tick();
    if (c < n) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic idle;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) tick();
    if (busy !== 1'b0) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic arm(input logic [1:0] ep);
    idle();
    req_arm = 1;
    req_ep = ep;
    req_size = 16'h0040;
    tick();
    req_arm = 0;
    for (int i = 0; i < 50 && lnk.active[ep] !== 1'b1; i++) tick();
    chk(32'(lnk.active[ep]), 32'h1);
  endtask
  // Whole packet; shorter than 64 bytes counts as short
  task automatic send(input logic [1:0] ep, input int n);
    for (int k = 0; k < n; k++) begin
      rx_valid = 1;
      rx_ep = ep;
      rx_data = 8'(k);
      rx_last = 1'(k == n - 1);
      tick();
    end
    rx_valid = 0;
    rx_last = 0;
  endtask
  // ====
  // Scenarios
  task automatic t_full;
    arm(2'h0);
    send(2'h0, 64);
    wait_ge(n_desc, 1);
    chk(32'(dq.pop_front()), 32'h00040);
    chk(32'(nb_d), 32'h40);
    chk(32'(lb_addr), 32'h3f);
    chk(32'(lb_data), 32'h3f);
    wait_ge(n_xd, 1);
    chk(32'(xfer_ep), 32'h0);
    $display("t_full finished");
  endtask
  task automatic t_short;
    logic [17:0] a, b;
    arm(2'h1);
    arm(2'h2);
    send(2'h1, 3);
    wait_ge(n_desc, 3);
    a = dq.pop_front();
    b = dq.pop_front();
    chk(32'(a + b), 32'h30003);
    chk(32'(a[17:16] * b[17:16]), 32'h2);
    wait_ge(n_a1, 2);
    chk(32'(sz1), 32'd61);
    chk(32'(n_xd), 32'h1);
    $display("t_short finished");
  endtask
  task automatic t_td;
    int k;
    for (int e = 1; e < 3; e++) begin
      idle();
      req_td = 1;
      req_ep = 2'(e);
      tick();
      req_td = 0;
      wait_ge(n_td, e);
      chk(32'(lnk.dma_en[e]), 32'h0);
    end
    chk(32'(lnk.hung), 32'h0);
    k = n_buf;
    send(2'h1, 4);
    tick(4);
    chk(32'(n_buf), 32'(k));
    $display("t_td finished");
  endtask
  task automatic t_pll;
    int k;
    arm(2'h0);
    pll_lock = 0;
    tick();
    pll_lock = 1;
    for (int i = 0; i < 20 && lnk.link_ok !== 1'b0; i++) tick();
    chk(32'(lnk.link_ok), 32'h0);
    k = n_buf;
    send(2'h0, 4);
    tick(4);
    chk(32'(n_buf), 32'(k));
    req_phy_rst = 1;
    tick(4);
    req_phy_rst = 0;
    for (int i = 0; i < 20 && lnk.link_ok !== 1'b1; i++) tick();
    chk(32'(lnk.link_ok), 32'h1);
    $display("t_pll finished");
  endtask
  initial begin
    {rx_valid, rx_last, req_arm, req_td, req_phy_rst, rstn} = '0;
    {rx_ep, req_ep, rx_data, req_size} = '0;
    pll_lock = 1;
    repeat (4) @(posedge sys_clk);
    #1 rstn = 1;
    t_full();
    t_short();
    t_td();
    t_pll();
    tally_and_finish();
  end
endmodule
